// ### udc_cfg.svh
// constants for the up/down edge counter block
`ifndef UDC_CFG_SVH
`define UDC_CFG_SVH

`define UDC_CNT_W 30
`define UDC_CNT_MAX 30'h3FFFFFFF
`define UDC_LIM_MAX 30'h05F5E0FF
`define UDC_OFF_MAX 30'h3B9AC9FF
`define UDC_CNT_ZERO 30'h00000000
`define UDC_CNT_ONE 30'h00000001

`define UDC_REG_CTRL 32'h00000000
`define UDC_REG_LIMIT 32'h00000004
`define UDC_REG_ON 32'h00000008
`define UDC_REG_OFF 32'h0000000C
`define UDC_REG_VALUE 32'h00000010
`define UDC_REG_STATUS 32'h00000014

`define UDC_IDX_CTRL 5'h00
`define UDC_IDX_LIMIT 5'h01
`define UDC_IDX_ON 5'h02
`define UDC_IDX_OFF 5'h03
`define UDC_IDX_VALUE 5'h04
`define UDC_IDX_STATUS 5'h05
`define UDC_IDX_NONE 5'h1F

`define UDC_CTRL_VARIANT 0
`define UDC_CTRL_FALLING 1
`define UDC_CTRL_RETAIN 2
`define UDC_CTRL_FAST 3
`define UDC_CTRL_W 4
`define UDC_CTRL_RST 4'h0

`define UDC_HTRANS_NONSEQ 2'h2
`define UDC_HTRANS_SEQ 2'h3
`define UDC_HTRANS_ACTIVE 1

`endif

// ### udc_pkg.sv
// types for the up/down edge counter block
package udc_pkg;
    typedef logic [29:0] udc_cnt_t;

    typedef struct packed {
        logic [3:0] ctrl;
        udc_cnt_t limit;
        udc_cnt_t on_thr;
        udc_cnt_t off_thr;
        udc_cnt_t count;
        logic result;
        logic cnt_sync1;
        logic cnt_sync2;
        logic cnt_prev;
        logic ph_valid;
        logic ph_write;
        logic [4:0] ph_addr;
        logic [31:0] rdata;
    } udc_state_t;
endpackage

// ### udc_counter.sv
// up/down edge counter with plain-limit and on/off threshold output variants
`timescale 1ns/1ps
`include "udc_cfg.svh"

module udc_counter
    import udc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic cnt_filtered,
    input wire logic cnt_fast,
    input wire logic dir,
    input wire logic clear,
    output logic result,
    output logic [29:0] value,
    output logic retain
);

    udc_state_t s;
    udc_state_t next_s;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [4:0] reg_index(input logic [31:0] a);
        logic [4:0] idx;
        // unmapped addresses keep the none code: they read 0 and ignore writes
        idx = `UDC_IDX_NONE;
        if (a == `UDC_REG_CTRL) begin
            idx = `UDC_IDX_CTRL;
        end else if (a == `UDC_REG_LIMIT) begin
            idx = `UDC_IDX_LIMIT;
        end else if (a == `UDC_REG_ON) begin
            idx = `UDC_IDX_ON;
        end else if (a == `UDC_REG_OFF) begin
            idx = `UDC_IDX_OFF;
        end else if (a == `UDC_REG_VALUE) begin
            idx = `UDC_IDX_VALUE;
        end else if (a == `UDC_REG_STATUS) begin
            idx = `UDC_IDX_STATUS;
        end
        return idx;
    endfunction

    // ranges enforced by clipping so the compare logic never sees out-of-range settings
    function automatic udc_cnt_t clip(input logic [31:0] d, input udc_cnt_t mx);
        udc_cnt_t v;
        v = (d > {2'h0, mx}) ? mx : d[29:0];
        return v;
    endfunction

    // address phase is taken only while the bus is ready and the transfer is active
    function automatic logic is_xfer(input logic sel, input logic rdy, input logic [1:0] tr);
        return sel && rdy && tr[`UDC_HTRANS_ACTIVE];
    endfunction

    logic cnt_pin;
    logic rise;
    logic fall;
    logic step;
    logic thr_result;
    logic [4:0] ridx;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_s = s;
        cnt_pin = s.ctrl[`UDC_CTRL_FAST] ? cnt_fast : cnt_filtered;
        // two flops plus a previous sample: a level change counts three edges later
        next_s.cnt_sync1 = cnt_pin;
        next_s.cnt_sync2 = s.cnt_sync1;
        next_s.cnt_prev = s.cnt_sync2;
        rise = s.cnt_sync2 & ~s.cnt_prev;
        fall = ~s.cnt_sync2 & s.cnt_prev;
        step = s.ctrl[`UDC_CTRL_FALLING] ? fall : rise;

        // saturate rather than wrap so a chattering input cannot roll the count over
        if (clear) begin
            next_s.count = `UDC_CNT_ZERO;
        end else if (step && !dir) begin
            if (s.count != `UDC_CNT_MAX) begin
                next_s.count = s.count + `UDC_CNT_ONE;
            end
        end else if (step && dir) begin
            if (s.count != `UDC_CNT_ZERO) begin
                next_s.count = s.count - `UDC_CNT_ONE;
            end
        end

        // result follows the count one cycle after it settles
        // on below off gives a window; otherwise a band in which result holds
        if (s.on_thr >= s.off_thr) begin
            if (s.count >= s.on_thr) begin
                thr_result = 1'b1;
            end else if (s.count < s.off_thr) begin
                thr_result = 1'b0;
            end else begin
                thr_result = s.result;
            end
        end else begin
            thr_result = (s.count >= s.on_thr) && (s.count < s.off_thr);
        end
        if (clear) begin
            next_s.result = 1'b0;
        end else if (s.ctrl[`UDC_CTRL_VARIANT]) begin
            next_s.result = thr_result;
        end else begin
            next_s.result = (s.count >= s.limit);
        end

        // bus: zero-wait slave, write lands in data phase
        ridx = reg_index(haddr);
        if (s.ph_valid && s.ph_write) begin
            if (s.ph_addr == `UDC_IDX_CTRL) begin
                next_s.ctrl = hwdata[`UDC_CTRL_W-1:0];
            end else if (s.ph_addr == `UDC_IDX_LIMIT) begin
                next_s.limit = clip(hwdata, `UDC_LIM_MAX);
            end else if (s.ph_addr == `UDC_IDX_ON) begin
                next_s.on_thr = clip(hwdata, `UDC_LIM_MAX);
            end else if (s.ph_addr == `UDC_IDX_OFF) begin
                next_s.off_thr = clip(hwdata, `UDC_OFF_MAX);
            end
        end
        // address phase captured here, acted on in the data phase
        next_s.ph_valid = is_xfer(hsel, hready, htrans);
        next_s.ph_write = hwrite;
        next_s.ph_addr = ridx;
        next_s.rdata = 32'h0;
        // next_s values let a read see a write whose data phase ends at the same edge
        if (is_xfer(hsel, hready, htrans) && !hwrite) begin
            if (ridx == `UDC_IDX_CTRL) begin
                next_s.rdata = {28'h0, next_s.ctrl};
            end else if (ridx == `UDC_IDX_LIMIT) begin
                next_s.rdata = {2'h0, next_s.limit};
            end else if (ridx == `UDC_IDX_ON) begin
                next_s.rdata = {2'h0, next_s.on_thr};
            end else if (ridx == `UDC_IDX_OFF) begin
                next_s.rdata = {2'h0, next_s.off_thr};
            end else if (ridx == `UDC_IDX_VALUE) begin
                next_s.rdata = {2'h0, s.count};
            end else if (ridx == `UDC_IDX_STATUS) begin
                next_s.rdata = {31'h0, s.result};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign hrdata = s.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign result = s.result;
    assign value = s.count;
    // retention itself lives outside; the block only presents the request bit
    assign retain = s.ctrl[`UDC_CTRL_RETAIN];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // antecedents that carry the sampled hresetn start no check at the release edge; the others do not carry it
    a_clear_zeroes_count: assert property (@(posedge hclk) disable iff (!hresetn)
        clear |=> (s.count == `UDC_CNT_ZERO))
        else $error("count not zero after clear");

    a_clear_zeroes_out: assert property (@(posedge hclk) disable iff (!hresetn)
        clear |=> !result)
        else $error("result not low after clear");

    a_up_step: assert property (@(posedge hclk) disable iff (!hresetn)
        (!clear && step && !dir && s.count != `UDC_CNT_MAX)
        |=> (s.count == $past(s.count) + `UDC_CNT_ONE))
        else $error("count did not step up");

    a_down_step: assert property (@(posedge hclk) disable iff (!hresetn)
        (!clear && step && dir && s.count != `UDC_CNT_ZERO)
        |=> (s.count == $past(s.count) - `UDC_CNT_ONE))
        else $error("count did not step down");

    a_no_edge_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (!clear && !step) |=> $stable(s.count))
        else $error("count moved without a selected edge");

    a_plain_result: assert property (@(posedge hclk) disable iff (!hresetn)
        (hresetn && !clear && !s.ctrl[`UDC_CTRL_VARIANT])
        |=> (result == $past(s.count >= s.limit)))
        else $error("plain result wrong");

    a_window_result: assert property (@(posedge hclk) disable iff (!hresetn)
        (!clear && s.ctrl[`UDC_CTRL_VARIANT] && s.on_thr < s.off_thr)
        |=> (result == $past(s.count >= s.on_thr && s.count < s.off_thr)))
        else $error("window result wrong");

    a_hyst_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (!clear && s.ctrl[`UDC_CTRL_VARIANT] && s.on_thr >= s.off_thr
         && s.count < s.on_thr && s.count >= s.off_thr) |=> $stable(result))
        else $error("hysteresis did not hold");

    a_value_tracks: assert property (@(posedge hclk) disable iff (!hresetn)
        value == s.count)
        else $error("value output not count");

    a_limit_range: assert property (@(posedge hclk) disable iff (!hresetn)
        s.limit <= `UDC_LIM_MAX && s.on_thr <= `UDC_LIM_MAX && s.off_thr <= `UDC_OFF_MAX)
        else $error("setting out of range");

    a_rise_only: assert property (@(posedge hclk) disable iff (!hresetn)
        (hresetn && !clear && !s.ctrl[`UDC_CTRL_FALLING] && fall) |=> $stable(s.count))
        else $error("falling edge counted in rising mode");

    a_fall_only: assert property (@(posedge hclk) disable iff (!hresetn)
        (hresetn && !clear && s.ctrl[`UDC_CTRL_FALLING] && rise) |=> $stable(s.count))
        else $error("rising edge counted in falling mode");

    a_sat_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (hresetn && !clear && step
         && ((dir && s.count == `UDC_CNT_ZERO) || (!dir && s.count == `UDC_CNT_MAX)))
        |=> $stable(s.count))
        else $error("count wrapped instead of saturating");

    a_clear_over_edge: assert property (@(posedge hclk) disable iff (!hresetn)
        (hresetn && clear && step) |=> (s.count == `UDC_CNT_ZERO))
        else $error("edge counted while clear high");

    a_hyst_set: assert property (@(posedge hclk) disable iff (!hresetn)
        (hresetn && !clear && s.ctrl[`UDC_CTRL_VARIANT] && s.on_thr >= s.off_thr
         && s.count >= s.on_thr) |=> result)
        else $error("result not set at on threshold");

    a_hyst_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        (hresetn && !clear && s.ctrl[`UDC_CTRL_VARIANT] && s.on_thr >= s.off_thr
         && s.count < s.off_thr) |=> !result)
        else $error("result not cleared below off threshold");

    a_fast_select: assert property (@(posedge hclk) disable iff (!hresetn)
        (hresetn && s.ctrl[`UDC_CTRL_FAST]) |=> (s.cnt_sync1 == $past(cnt_fast)))
        else $error("fast path not selected");

    a_slow_select: assert property (@(posedge hclk) disable iff (!hresetn)
        (hresetn && !s.ctrl[`UDC_CTRL_FAST]) |=> (s.cnt_sync1 == $past(cnt_filtered)))
        else $error("filtered path not selected");

    // ----------------------------------------
    // bus checks
    // ----------------------------------------
    a_value_read: assert property (@(posedge hclk) disable iff (!hresetn)
        (s.ph_valid && !s.ph_write && s.ph_addr == `UDC_IDX_VALUE)
        |-> (hrdata == {2'h0, $past(value)}))
        else $error("value register read wrong");

    a_status_read: assert property (@(posedge hclk) disable iff (!hresetn)
        (s.ph_valid && !s.ph_write && s.ph_addr == `UDC_IDX_STATUS)
        |-> (hrdata == {31'h0, $past(result)}))
        else $error("status register read wrong");

    a_limit_clip: assert property (@(posedge hclk) disable iff (!hresetn)
        (hresetn && s.ph_valid && s.ph_write && s.ph_addr == `UDC_IDX_LIMIT
         && hwdata > {2'h0, `UDC_LIM_MAX}) |=> (s.limit == `UDC_LIM_MAX))
        else $error("limit not clipped");

    a_off_clip: assert property (@(posedge hclk) disable iff (!hresetn)
        (hresetn && s.ph_valid && s.ph_write && s.ph_addr == `UDC_IDX_OFF
         && hwdata > {2'h0, `UDC_OFF_MAX}) |=> (s.off_thr == `UDC_OFF_MAX))
        else $error("off threshold not clipped");

endmodule

// ### udc_src.sv
// stand-in for the input filter feeding the slow and fast count lines
`timescale 1ns/1ps
module udc_src (
    input wire logic hclk,
    input wire logic lvl,
    input wire logic use_fast,
    output logic cnt_filtered,
    output logic cnt_fast
);
    // the line not in use idles low, so a path switch at lvl 0 adds no edge
    always_ff @(posedge hclk) begin
        cnt_filtered <= use_fast ? 1'b0 : lvl;
        cnt_fast <= use_fast ? lvl : 1'b0;
    end
endmodule

// ### udc_counter_tb_top.sv
// self-checking bench for the up/down edge counter
`timescale 1ns/1ps
`include "udc_cfg.svh"
module udc_counter_tb_top;
    import udc_pkg::*;
    logic hclk, hresetn, hsel, hwrite, dir, clear, lvl, use_fast;
    logic hreadyout, hresp, result, retain, cnt_filtered, cnt_fast;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [29:0] value;
    int n_fail = 0;
    int compares = 0;
    udc_counter udc_counter_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cnt_filtered(cnt_filtered),
        .cnt_fast(cnt_fast), .dir(dir), .clear(clear), .result(result), .value(value),
        .retain(retain));
    udc_src udc_src_i (.hclk(hclk), .lvl(lvl), .use_fast(use_fast),
        .cnt_filtered(cnt_filtered), .cnt_fast(cnt_fast));
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= `UDC_HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd(input string what, input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        chk(what, exp, q);
    endtask
    // one full pulse per step; waits out sync, count and result latency
    task automatic cnt(input logic d, input int n);
        repeat (n) begin
            @(posedge hclk);
            dir <= d;
            lvl <= 1'b1;
            repeat (3) @(posedge hclk);
            lvl <= 1'b0;
            repeat (3) @(posedge hclk);
        end
        repeat (4) @(posedge hclk);
    endtask
    task automatic edge_to(input logic v);
        @(posedge hclk);
        lvl <= v;
        repeat (8) @(posedge hclk);
    endtask
    task automatic st(input logic [29:0] v, input logic r);
        chk("value", {2'h0, v}, {2'h0, value});
        chk("result", {31'h0, r}, {31'h0, result});
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        st(30'h0, 1'b0);
        chk("hresp", 32'h0, {31'h0, hresp});
        chk("hreadyout", 32'h1, {31'h0, hreadyout});
        chk("retain", 32'h0, {31'h0, retain});
        rd("ctrl", `UDC_REG_CTRL, 32'h0);
        rd("unmapped", 32'h00000018, 32'h0);
    endtask
    task automatic t_plain();
        bus(1'b1, `UDC_REG_LIMIT, 32'h00000003);
        edge_to(1'b1);
        chk("value", 32'h1, {2'h0, value});
        edge_to(1'b0);
        chk("value", 32'h1, {2'h0, value});
        cnt(1'b0, 1);
        st(30'h2, 1'b0);
        cnt(1'b0, 1);
        st(30'h3, 1'b1);
        rd("value reg", `UDC_REG_VALUE, 32'h3);
        rd("status", `UDC_REG_STATUS, 32'h1);
        cnt(1'b1, 1);
        st(30'h2, 1'b0);
    endtask
    task automatic t_clear();
        @(posedge hclk);
        clear <= 1'b1;
        cnt(1'b0, 2);
        st(30'h0, 1'b0);
        clear <= 1'b0;
        cnt(1'b1, 1);
        st(30'h0, 1'b0);
    endtask
    task automatic t_fall_fast();
        bus(1'b1, `UDC_REG_CTRL, 32'h0000000A);
        use_fast <= 1'b1;
        // the clear scenario left dir at down; this one expects an up step
        dir <= 1'b0;
        edge_to(1'b1);
        chk("value", 32'h0, {2'h0, value});
        edge_to(1'b0);
        chk("value", 32'h1, {2'h0, value});
        use_fast <= 1'b0;
    endtask
    task automatic t_thr();
        bus(1'b1, `UDC_REG_ON, 32'h00000003);
        bus(1'b1, `UDC_REG_OFF, 32'h00000001);
        bus(1'b1, `UDC_REG_CTRL, 32'h00000001);
        cnt(1'b0, 1);
        st(30'h2, 1'b0);
        cnt(1'b0, 1);
        st(30'h3, 1'b1);
        cnt(1'b1, 2);
        st(30'h1, 1'b1);
        cnt(1'b1, 1);
        st(30'h0, 1'b0);
        bus(1'b1, `UDC_REG_ON, 32'h00000001);
        bus(1'b1, `UDC_REG_OFF, 32'h00000003);
        cnt(1'b0, 1);
        st(30'h1, 1'b1);
        cnt(1'b0, 2);
        st(30'h3, 1'b0);
        clear <= 1'b1;
        cnt(1'b0, 1);
        st(30'h0, 1'b0);
        clear <= 1'b0;
    endtask
    task automatic t_clip();
        bus(1'b1, `UDC_REG_LIMIT, 32'hFFFFFFFF);
        rd("limit", `UDC_REG_LIMIT, {2'h0, `UDC_LIM_MAX});
        bus(1'b1, `UDC_REG_ON, 32'hFFFFFFFF);
        rd("on", `UDC_REG_ON, {2'h0, `UDC_LIM_MAX});
        bus(1'b1, `UDC_REG_OFF, 32'hFFFFFFFF);
        rd("off", `UDC_REG_OFF, {2'h0, `UDC_OFF_MAX});
        bus(1'b1, `UDC_REG_CTRL, 32'h00000004);
        // the write lands at the edge that ends the data phase
        @(posedge hclk);
        chk("retain", 32'h1, {31'h0, retain});
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        dir = 1'b0;
        clear = 1'b0;
        lvl = 1'b0;
        use_fast = 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_plain();
        t_clear();
        t_fall_fast();
        t_thr();
        t_clip();
        print_verdict();
    end
    initial begin
        repeat (5000) @(posedge hclk);
        n_fail++;
        print_verdict();
    end
endmodule
